// ==== cs_stepper.sv ====
`timescale 1ns/1ps
// Per coordinate system step gate that picks a step or a quit pulse by run mode.
module cs_stepper
  import ctrl_char_pkg::*;
#(
  parameter int N = NUM_CS
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic step_req,
  input wire logic [N-1:0] has_motor,
  input wire logic [N-1:0] has_prog,
  input wire logic [N-1:0] running,
  output logic [N-1:0] step_pulse,
  output logic [N-1:0] quit_pulse
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cs
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          step_pulse[g] <= 1'b0;
          quit_pulse[g] <= 1'b0;
        end else begin
          step_pulse[g] <= step_req && has_motor[g] && has_prog[g] && !running[g];
          quit_pulse[g] <= step_req && has_motor[g] && has_prog[g] && running[g];
        end
      end
    end
  endgenerate
endmodule

// ==== ctrl_char_pkg.sv ====
package ctrl_char_pkg;
  localparam logic [7:0] CHR_ENTER = 8'h0D;
  localparam logic [7:0] CHR_STEP = 8'h13;
  localparam logic [7:0] CHR_DUPLEX = 8'h14;
  localparam logic [7:0] CHR_OPEN_ROT = 8'h15;
  localparam logic [7:0] CHR_VEL = 8'h16;
  localparam logic [7:0] CHR_CANCEL = 8'h18;
  localparam logic [7:0] CHR_RECALL = 8'h19;
  localparam logic [7:0] CHR_SPACE = 8'h20;
  localparam logic [7:0] CHR_ZERO = 8'h30;
  localparam logic [7:0] CHR_MINUS = 8'h2D;
  localparam logic [7:0] CHR_POINT = 8'h2E;
  localparam int LINE_DEPTH = 32;
  localparam int NUM_MOTORS = 8;
  localparam int NUM_CS = 8;
  localparam int POS_W = 24;
  // Register port map.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_CS_MOTOR = 4'h2;
  localparam logic [3:0] ADDR_CS_PROG = 4'h3;
  localparam logic [3:0] ADDR_CS_RUN = 4'h4;
  localparam int CTRL_ACK_BIT = 0;
  localparam int CTRL_SEL_BIT = 1;
  localparam int CTRL_CHAIN_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h02;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_ACK = 6'b00_0010,
    ST_RECALL = 6'b00_0100,
    ST_VEL = 6'b00_1000,
    ST_VEL_SEP = 6'b01_0000,
    ST_VEL_END = 6'b10_0000
  } reply_state_t;
endpackage

// ==== host_control_char_decoder.sv ====
`timescale 1ns/1ps
// What this block does
// - Byte 13h steps every coordinate system at once.
// - Steps reach only systems with a motor and a program.
// - Idle program runs through its next move or dwell.
// - Running program is switched to single step, like quit.
// - Step and cancel act on every chained card.
// - Byte 14h toggles echo while the chain bit is clear; full duplex echoes each received character except 18h.
// - Echo starts in half duplex after reset.
// - Byte 15h opens every rotary buffer.
// - Byte 16h reports every motor velocity, counts per servo cycle.
// - Velocity is difference of consecutive servo positions.
// - Velocity report only from the selected card.
// - Byte 18h aborts replies and flushes the command queue.
// - Byte 19h sends last line without return and reloads it.
// - Internally issued commands replace the stored last line.
// - Control bytes act at once; 0Dh interprets the line.
module host_control_char_decoder
  import ctrl_char_pkg::*;
#(
  parameter int MOTORS = NUM_MOTORS,
  parameter int CS = NUM_CS,
  parameter int DEPTH = LINE_DEPTH
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic servo_tick,
  input wire logic [MOTORS*POS_W-1:0] motor_pos,
  input wire logic int_cmd_valid,
  input wire logic [7:0] int_cmd_char,
  input wire logic int_cmd_end,
  output logic line_exec,
  output logic [7:0] line_len,
  output logic [CS-1:0] step_pulse,
  output logic [CS-1:0] quit_pulse,
  output logic open_rotary
);
  logic [7:0] ctrl_reg;
  logic [CS-1:0] cs_motor_reg, cs_prog_reg, cs_run_reg;
  logic full_duplex_reg;
  logic [7:0] rx_buf [0:DEPTH-1];
  logic [7:0] last_buf [0:DEPTH-1];
  logic [7:0] int_buf [0:DEPTH-1];
  logic [7:0] rx_len_reg, last_len_reg, int_len_reg, tx_idx_reg, mot_idx_reg;
  logic signed [POS_W-1:0] prev_pos [0:MOTORS-1];
  logic signed [POS_W-1:0] vel_reg [0:MOTORS-1];
  logic echo_pend_reg;
  logic [7:0] echo_chr_reg;
  reply_state_t state_reg;
  reply_state_t state_next;
  logic is_ctrl, do_step, do_cancel, do_recall, do_vel, do_enter;
  logic fmt_load, fmt_take, fmt_busy;
  logic [7:0] fmt_chr;
  logic rec_chr;

  assign is_ctrl = rx_valid && (rx_data < CHR_SPACE);
  // step reaches all cards regardless of selection.
  assign do_step = rx_valid && rx_data == CHR_STEP;
  assign do_cancel = rx_valid && rx_data == CHR_CANCEL;
  assign do_recall = rx_valid && rx_data == CHR_RECALL;
  assign do_vel = rx_valid && rx_data == CHR_VEL && ctrl_reg[CTRL_SEL_BIT];
  assign do_enter = rx_valid && rx_data == CHR_ENTER;
  assign rec_chr = rx_valid && !is_ctrl;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RESET;
      cs_motor_reg <= '0;
      cs_prog_reg <= '0;
      cs_run_reg <= '0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_CTRL) begin
        ctrl_reg <= reg_wdata;
      end else if (reg_addr == ADDR_CS_MOTOR) begin
        cs_motor_reg <= CS'(reg_wdata);
      end else if (reg_addr == ADDR_CS_PROG) begin
        cs_prog_reg <= CS'(reg_wdata);
      end else if (reg_addr == ADDR_CS_RUN) begin
        cs_run_reg <= CS'(reg_wdata);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_CTRL) begin
        reg_rdata <= ctrl_reg;
      end else if (reg_addr == ADDR_STATUS) begin
        reg_rdata <= {5'h00, state_reg != ST_IDLE, echo_pend_reg, full_duplex_reg};
      end else if (reg_addr == ADDR_CS_MOTOR) begin
        reg_rdata <= 8'(cs_motor_reg);
      end else if (reg_addr == ADDR_CS_PROG) begin
        reg_rdata <= 8'(cs_prog_reg);
      end else if (reg_addr == ADDR_CS_RUN) begin
        reg_rdata <= 8'(cs_run_reg);
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // half duplex at reset, 14h toggles while the chain bit is clear.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      full_duplex_reg <= 1'b0;
    end else if (rx_valid && rx_data == CHR_DUPLEX && !ctrl_reg[CTRL_CHAIN_BIT]) begin
      full_duplex_reg <= !full_duplex_reg;
    end
  end

  // echo each character except 18h in full duplex.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      echo_pend_reg <= 1'b0;
      echo_chr_reg <= 8'h00;
    end else if (rx_valid && full_duplex_reg && !do_cancel) begin
      echo_pend_reg <= 1'b1;
      echo_chr_reg <= rx_data;
    end else if (do_cancel || (echo_pend_reg && tx_ready && state_reg == ST_IDLE)) begin
      echo_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      open_rotary <= 1'b0;
    end else begin
      open_rotary <= rx_valid && rx_data == CHR_OPEN_ROT;
    end
  end

  // line kept except on cancel flush, enter or recall reload.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rx_len_reg <= 8'h00;
      line_exec <= 1'b0;
      line_len <= 8'h00;
    end else begin
      line_exec <= do_enter;
      if (do_cancel) begin
        rx_len_reg <= 8'h00;
      end else if (do_enter) begin
        line_len <= rx_len_reg;
        rx_len_reg <= 8'h00;
      end else if (do_recall) begin
        rx_len_reg <= last_len_reg;
        for (int i = 0; i < DEPTH; i++) rx_buf[i] <= last_buf[i];
      end else if (rec_chr && rx_len_reg < 8'(DEPTH)) begin
        rx_buf[rx_len_reg[$clog2(DEPTH)-1:0]] <= rx_data;
        rx_len_reg <= rx_len_reg + 8'h01;
      end
    end
  end

  // internal commands overwrite the last line.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      last_len_reg <= 8'h00;
      int_len_reg <= 8'h00;
    end else begin
      if (int_cmd_end) begin
        last_len_reg <= int_len_reg;
        for (int i = 0; i < DEPTH; i++) last_buf[i] <= int_buf[i];
        int_len_reg <= 8'h00;
      end else if (do_enter) begin
        last_len_reg <= rx_len_reg;
        for (int i = 0; i < DEPTH; i++) last_buf[i] <= rx_buf[i];
      end
      if (int_cmd_valid && !int_cmd_end && int_len_reg < 8'(DEPTH)) begin
        int_buf[int_len_reg[$clog2(DEPTH)-1:0]] <= int_cmd_char;
        int_len_reg <= int_len_reg + 8'h01;
      end
    end
  end

  // raw difference of consecutive servo positions.
  generate
    for (genvar m = 0; m < MOTORS; m++) begin : g_mot
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          prev_pos[m] <= '0;
          vel_reg[m] <= '0;
        end else if (servo_tick) begin
          prev_pos[m] <= motor_pos[m*POS_W +: POS_W];
          vel_reg[m] <= POS_W'(motor_pos[m*POS_W +: POS_W] - prev_pos[m]);
        end
      end
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (do_cancel && ctrl_reg[CTRL_ACK_BIT]) state_next = ST_ACK;
        else if (do_recall && last_len_reg != 8'h00) state_next = ST_RECALL;
        else if (do_vel) state_next = ST_VEL;
      end
      ST_ACK: if (tx_ready) state_next = ST_IDLE;
      ST_RECALL: if (tx_ready && tx_idx_reg + 8'h01 >= last_len_reg) state_next = ST_IDLE;
      ST_VEL: if (tx_ready && fmt_take && !fmt_busy) state_next = ST_VEL_SEP;
      ST_VEL_SEP: begin
        if (mot_idx_reg + 8'h01 >= 8'(MOTORS)) state_next = ST_VEL_END;
        else state_next = ST_VEL;
      end
      ST_VEL_END: if (tx_ready) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
    // cancel aborts any reply in progress.
    if (do_cancel && state_reg != ST_IDLE) begin
      state_next = ctrl_reg[CTRL_ACK_BIT] ? ST_ACK : ST_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      tx_idx_reg <= 8'h00;
      mot_idx_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_RECALL && tx_ready) tx_idx_reg <= tx_idx_reg + 8'h01;
      else if (state_reg == ST_IDLE) tx_idx_reg <= 8'h00;
      if (state_reg == ST_VEL_SEP) mot_idx_reg <= mot_idx_reg + 8'h01;
      else if (state_reg == ST_IDLE) mot_idx_reg <= 8'h00;
    end
  end

  assign fmt_load = (state_reg == ST_IDLE && state_next == ST_VEL) ||
                    (state_reg == ST_VEL_SEP && state_next == ST_VEL);
  assign fmt_take = state_reg == ST_VEL && (tx_ready || fmt_chr == 8'h00);

  vel_format #(.W(POS_W)) u_fmt (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(fmt_load),
    .value(fmt_load ? vel_reg[state_reg == ST_IDLE ? 0 : 3'(mot_idx_reg + 8'h01)]
                    : vel_reg[0]),
    .take(fmt_take),
    .chr(fmt_chr),
    .busy(fmt_busy)
  );

  always_comb begin
    tx_valid = 1'b0;
    tx_data = 8'h00;
    case (state_reg)
      ST_ACK: begin
        tx_valid = 1'b1;
        tx_data = CHR_CANCEL;
      end
      // no trailing return after the recalled line.
      ST_RECALL: begin
        tx_valid = 1'b1;
        tx_data = last_buf[tx_idx_reg[$clog2(DEPTH)-1:0]];
      end
      ST_VEL: begin
        tx_valid = fmt_busy && fmt_chr != 8'h00;
        tx_data = fmt_chr;
      end
      ST_VEL_END: begin
        tx_valid = 1'b1;
        tx_data = CHR_ENTER;
      end
      default: begin
        tx_valid = echo_pend_reg && state_reg == ST_IDLE;
        tx_data = echo_chr_reg;
      end
    endcase
  end

  cs_stepper #(.N(CS)) u_step (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .step_req(do_step),
    .has_motor(cs_motor_reg),
    .has_prog(cs_prog_reg),
    .running(cs_run_reg),
    .step_pulse(step_pulse),
    .quit_pulse(quit_pulse)
  );

  a_echo_reset: assert property (@(posedge core_clk) $fell(sys_rst) |-> !full_duplex_reg)
    else $error("duplex not half after reset");
  a_duplex_toggle: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rx_valid && rx_data == CHR_DUPLEX && !ctrl_reg[CTRL_CHAIN_BIT]) |=>
    full_duplex_reg != $past(full_duplex_reg)) else $error("duplex not toggled");
  a_cancel_ack: assert property (@(posedge core_clk) disable iff (sys_rst)
    (do_cancel && ctrl_reg[CTRL_ACK_BIT]) |=> tx_valid && tx_data == CHR_CANCEL)
    else $error("cancel ack missing");
  a_cancel_flush: assert property (@(posedge core_clk) disable iff (sys_rst)
    do_cancel |=> rx_len_reg == 8'h00) else $error("queue not flushed");
  a_step_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    ##1 (step_pulse & ~$past(cs_motor_reg & cs_prog_reg)) == '0) else $error("bad step");
  a_step_all: assert property (@(posedge core_clk) disable iff (sys_rst)
    do_step |=> step_pulse == $past(cs_motor_reg & cs_prog_reg & ~cs_run_reg))
    else $error("step missed");
  a_enter_exec: assert property (@(posedge core_clk) disable iff (sys_rst)
    do_enter |=> line_exec) else $error("line not executed");
  a_vel_select: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_reg == ST_IDLE && rx_valid && rx_data == CHR_VEL && !ctrl_reg[CTRL_SEL_BIT])
    |=> state_reg != ST_VEL) else $error("unselected report");
endmodule

// ==== host_model.sv ====
`timescale 1ns/1ps
// Host end of the reply link; it collects every byte that the block hands over.
module host_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] got[$];
  int phase;
  // A slow host accepts only every third cycle, so replies must hold under back-pressure.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      tx_ready <= 1'b0;
      phase <= 0;
    end else begin
      if (tx_valid && tx_ready) begin
        got.push_back(tx_data);
      end
      phase <= (phase + 1) % 3;
      tx_ready <= !slow || (phase == 0);
    end
  end
endmodule

// ==== test_host_control_char_decoder.sv ====
`timescale 1ns/1ps
module test_host_control_char_decoder
  import ctrl_char_pkg::*;
();
  logic core_clk, sys_rst, reg_wr, reg_rd, rx_valid, servo_tick, slow;
  logic int_cmd_valid, int_cmd_end, tx_valid, tx_ready, line_exec, open_rotary;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rx_data, tx_data, int_cmd_char, line_len, rd;
  logic [NUM_MOTORS*POS_W-1:0] motor_pos;
  logic [NUM_CS-1:0] step_pulse, quit_pulse;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  int d2[NUM_MOTORS] = '{5, -12, 1234, 0, 0, 0, 0, -1};
  string s;

  host_control_char_decoder uut (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .servo_tick(servo_tick), .motor_pos(motor_pos),
    .int_cmd_valid(int_cmd_valid), .int_cmd_char(int_cmd_char), .int_cmd_end(int_cmd_end),
    .line_exec(line_exec), .line_len(line_len), .step_pulse(step_pulse),
    .quit_pulse(quit_pulse), .open_rotary(open_rotary));

  host_model host (.core_clk(core_clk), .sys_rst(sys_rst), .slow(slow),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // The whole sequence needs a few thousand cycles, well below the 20000-cycle ceiling that stops a hang.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("ERROR at %0t: timeout", $time);
      summarize();
    end
  end

  task automatic check_val(input logic [7:0] act, input logic [7:0] exp, input string what);
    n_checks++;
    if (act !== exp) begin
      miscompares++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, act, exp);
    end
  endtask

  task automatic check_bytes(input string exp, input string what);
    logic ok;
    ok = (host.got.size() == exp.len());
    for (int i = 0; ok && i < exp.len(); i++) ok = (host.got[i] === exp[i]);
    n_checks++;
    if (!ok) begin
      miscompares++;
      $display("ERROR at %0t: %s reply wrong, %0d bytes", $time, what, host.got.size());
    end
    host.got.delete();
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask

  // Leaves the core just after the edge that took the byte, when its pulses stand.
  task automatic send(input logic [7:0] b);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
    #1;
  endtask

  task automatic send_str(input string t);
    for (int i = 0; i < t.len(); i++) send(t[i]);
  endtask

  task automatic wait_bytes(input int n);
    for (int i = 0; i < 600 && host.got.size() < n; i++) @(posedge core_clk);
  endtask

  task automatic tick(input int k);
    @(posedge core_clk);
    for (int m = 0; m < NUM_MOTORS; m++) begin
      motor_pos[m*POS_W +: POS_W] <= POS_W'(1000 * m + (k > 0 ? 7 : 0) + (k > 1 ? d2[m] : 0));
    end
    servo_tick <= 1'b1;
    @(posedge core_clk);
    servo_tick <= 1'b0;
  endtask

  initial begin
    {reg_wr, reg_rd, rx_valid, servo_tick, int_cmd_valid, int_cmd_end, slow} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    rx_data = '0;
    int_cmd_char = '0;
    motor_pos = '0;
    sys_rst = 1'b1;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    send(CHR_CANCEL);
    reg_read(ADDR_CTRL);
    check_val(rd, CTRL_RESET, "ctrl reset");
    reg_read(4'hF);
    check_val(rd, 8'h00, "unmapped");
    reg_read(ADDR_STATUS);
    check_val(rd & 8'h01, 8'h00, "duplex reset");
    send("A");
    wait_bytes(1);
    check_bytes("", "half duplex");
    send(CHR_DUPLEX);
    wait_bytes(1);
    host.got.delete();
    reg_read(ADDR_STATUS);
    check_val(rd & 8'h01, 8'h01, "full duplex");
    send("Z");
    wait_bytes(1);
    check_bytes("Z", "echo");
    send(CHR_DUPLEX);
    wait_bytes(1);
    host.got.delete();
    send(CHR_CANCEL);
    wait_bytes(1);
    check_bytes("", "no ack");
    send_str("XY");
    send(CHR_OPEN_ROT);
    check_val(8'(open_rotary), 8'h01, "open rotary");
    send(CHR_ENTER);
    check_val(8'(line_exec), 8'h01, "exec");
    check_val(line_len, 8'h02, "line kept");
    send_str("AB");
    send(CHR_CANCEL);
    send_str("C");
    send(CHR_ENTER);
    check_val(line_len, 8'h01, "flushed");
    reg_write(ADDR_CS_MOTOR, 8'hF5);
    reg_write(ADDR_CS_PROG, 8'h7E);
    reg_write(ADDR_CS_RUN, 8'h0F);
    reg_write(ADDR_CTRL, 8'h05);
    send(CHR_STEP);
    check_val(step_pulse, 8'h70, "step");
    check_val(quit_pulse, 8'h04, "quit");
    @(posedge core_clk);
    #1;
    check_val(step_pulse | quit_pulse, 8'h00, "single pulse");
    send(CHR_CANCEL);
    wait_bytes(1);
    check_bytes($sformatf("%c", CHR_CANCEL), "ack unselected");
    for (int k = 0; k < 3; k++) tick(k);
    send(CHR_VEL);
    wait_bytes(1);
    check_bytes("", "unselected");
    reg_write(ADDR_CTRL, 8'h06);
    slow <= 1'b1;
    s = "";
    foreach (d2[m]) s = {s, $sformatf("%0d.0 ", d2[m])};
    s = {s, $sformatf("%c", CHR_ENTER)};
    send(CHR_VEL);
    wait_bytes(s.len());
    check_bytes(s, "velocity");
    reg_write(ADDR_CTRL, 8'h07);
    send(CHR_VEL);
    wait_bytes(4);
    send(CHR_CANCEL);
    wait_bytes(host.got.size() + 2);
    check_val(host.got[$], CHR_CANCEL, "abort ack");
    check_val(8'(host.got.size() < s.len()), 8'h01, "aborted");
    host.got.delete();
    slow <= 1'b0;
    reg_write(ADDR_CTRL, 8'h02);
    send_str("P12");
    send(CHR_ENTER);
    send(CHR_RECALL);
    wait_bytes(3);
    check_bytes("P12", "recall");
    send(CHR_ENTER);
    check_val(8'(line_exec), 8'h01, "reload exec");
    check_val(line_len, 8'h03, "reload len");
    s = "M7";
    for (int i = 0; i < s.len(); i++) begin
      @(posedge core_clk);
      int_cmd_valid <= 1'b1;
      int_cmd_char <= s[i];
    end
    @(posedge core_clk);
    int_cmd_valid <= 1'b0;
    int_cmd_end <= 1'b1;
    @(posedge core_clk);
    int_cmd_end <= 1'b0;
    send(CHR_RECALL);
    wait_bytes(2);
    check_bytes("M7", "internal recall");
    summarize();
  end
endmodule

// ==== vel_format.sv ====
`timescale 1ns/1ps
// Turns one signed count-per-cycle velocity into "-dddddddd.0 " characters.
module vel_format
  import ctrl_char_pkg::*;
#(
  parameter int W = POS_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic signed [W-1:0] value,
  input wire logic take,
  output logic [7:0] chr,
  output logic busy
);
  logic [W-1:0] mag_reg;
  logic neg_reg;
  logic [3:0] digits_reg [0:7];
  logic [3:0] idx_reg;
  logic started_reg;
  logic [W-1:0] mag_abs;

  assign mag_abs = value[W-1] ? W'(-value) : value;

  // Whole counts only, so the rounded tenth is always zero.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      idx_reg <= 4'h0;
      neg_reg <= 1'b0;
      mag_reg <= '0;
      started_reg <= 1'b0;
      for (int i = 0; i < 8; i++) digits_reg[i] <= 4'h0;
    end else if (load) begin
      neg_reg <= value[W-1];
      mag_reg <= mag_abs;
      idx_reg <= 4'h0;
      started_reg <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        digits_reg[i] <= 4'((mag_abs / W'(10 ** (7 - i))) % W'(10));
      end
    end else if (take && busy) begin
      idx_reg <= idx_reg + 4'h1;
      if (idx_reg >= 4'h1 && idx_reg <= 4'h8) begin
        started_reg <= started_reg | (digits_reg[3'(idx_reg - 4'h1)] != 4'h0);
      end
    end
  end

  // The separating space is the last character of every field, so the host can split them.
  assign busy = idx_reg < 4'hC;

  always_comb begin
    chr = CHR_SPACE;
    if (idx_reg == 4'h0) begin
      chr = neg_reg ? CHR_MINUS : 8'h00;
    end else if (idx_reg <= 4'h8) begin
      chr = CHR_ZERO + 8'(digits_reg[3'(idx_reg - 4'h1)]);
      if (!started_reg && digits_reg[3'(idx_reg - 4'h1)] == 4'h0 && idx_reg != 4'h8) begin
        chr = 8'h00;
      end
    end else if (idx_reg == 4'h9) begin
      chr = CHR_POINT;
    end else if (idx_reg == 4'hA) begin
      chr = CHR_ZERO;
    end
  end
endmodule
